// ==== src/xpt_defines.vh ====
`ifndef XPT_DEFINES_VH
`define XPT_DEFINES_VH
`define DEV_ADDR_RESET 7'h70
`define ON_OFF_POS 7
`define X_MSB_POS 6
`define X_LSB_POS 3
`define Y_MSB_POS 2
`define Y_LSB_POS 0
// X field codes: two groups of used codes, the rest reserved
`define XC_LOW_FIRST 4'h2
`define XC_LOW_LAST 4'h5
`define XC_HIGH_FIRST 4'h8
`define XC_HIGH_LAST 4'hd
`define XC_HIGH_BASE 4'h4
`define LOAD_POS 0
`define NUM_X 10
`define NUM_Y 8
`define RB_X0 8'h74
`define RB_X1 8'h7c
`define RB_X2 8'h35
`define RB_X3 8'h3d
`define RB_X4 8'h75
`define RB_X5 8'h7d
`define RB_X6 8'h36
`define RB_X7 8'h3e
`define RB_X8 8'h76
`define RB_X9 8'h7e
`endif

// ==== src/pin_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for asynchronous pin levels
module pin_sync #(
    parameter WIDTH = 2
) (
    input wire mclk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    // First stage, read only by second stage
    reg [WIDTH-1:0] meta_q;

    // Idle bus level is high
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== src/i2c_crosspoint_switch_control.v ====
`timescale 1ns/1ps
`default_nettype none
`include "xpt_defines.vh"
// I2C target for a 10 x 8 crosspoint switch array
module i2c_crosspoint_switch_control #(
    parameter NX = `NUM_X,
    parameter NY = `NUM_Y
) (
    input wire mclk,
    input wire sys_rst,
    input wire [6:0] dev_addr,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    output reg [NX*NY-1:0] switch_state
);
    // States, one-hot
    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RX = 5'h02;
    localparam [4:0] S_ACK = 5'h04;
    localparam [4:0] S_TX = 5'h08;
    localparam [4:0] S_MACK = 5'h10;

    // Synchronised bus lines
    wire [1:0] bus_s;
    reg scl_q;
    reg sda_q;
    pin_sync #(.WIDTH(2)) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .async_in({scl_in, sda_in}),
        .sync_out(bus_s)
    );
    wire scl_s = bus_s[1];
    wire sda_s = bus_s[0];
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    // Start and stop: data moves while clock is high
    wire start_c = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_c = scl_s & scl_q & ~sda_q & sda_s;

    reg [4:0] state_q;
    reg [7:0] shift_q;        // Receive or transmit shifter
    reg [3:0] bit_q;          // Bits seen in current byte
    reg [1:0] byte_q;         // Bytes seen since start, address included
    reg rw_q;                 // Direction of current transfer
    reg [7:0] cmd_q;          // First data byte held
    reg [7:0] hold_q;         // Readback holding register
    reg rb_sel_q;             // First byte was a readback code
    reg [3:0] rb_x_q;         // Decoded readback X line
    reg [NX*NY-1:0] input_q;  // Input buffer of switch states
    reg [NX*NY-1:0] input_d;
    reg sel_hit;
    reg [3:0] sel_x;
    reg x_hit;                // X field names a real line
    reg [3:0] x_idx;          // X line index from the X field
    wire [3:0] cmd_x = cmd_q[`X_MSB_POS:`X_LSB_POS];
    wire [2:0] cmd_y = cmd_q[`Y_MSB_POS:`Y_LSB_POS];

    always @* begin
        sel_hit = 1'b1;
        sel_x = 4'h0;
        case (shift_q)
            `RB_X0: sel_x = 4'h0;
            `RB_X1: sel_x = 4'h1;
            `RB_X2: sel_x = 4'h2;
            `RB_X3: sel_x = 4'h3;
            `RB_X4: sel_x = 4'h4;
            `RB_X5: sel_x = 4'h5;
            `RB_X6: sel_x = 4'h6;
            `RB_X7: sel_x = 4'h7;
            `RB_X8: sel_x = 4'h8;
            `RB_X9: sel_x = 4'h9;
            default: sel_hit = 1'b0;
        endcase
    end

    // X field code to line index
    // Codes are not binary line numbers; gaps are reserved
    always @* begin
        x_hit = 1'b1;
        x_idx = 4'h0;
        if (cmd_x >= `XC_LOW_FIRST && cmd_x <= `XC_LOW_LAST) begin
            // Lower group: first four lines
            x_idx = cmd_x - `XC_LOW_FIRST;
        end else if (cmd_x >= `XC_HIGH_FIRST && cmd_x <= `XC_HIGH_LAST) begin
            // Upper group: remaining six lines
            x_idx = cmd_x - `XC_HIGH_FIRST + `XC_HIGH_BASE;
        end else begin
            // Reserved code: no switch touched
            x_hit = 1'b0;
        end
    end

    always @* begin
        input_d = input_q;
        if (x_hit && x_idx < NX[3:0])
            input_d[x_idx*NY + cmd_y] = cmd_q[`ON_OFF_POS];
    end

    // Protocol engine
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            state_q <= S_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            rw_q <= 1'b0;
            cmd_q <= 8'h00;
            hold_q <= 8'h00;
            rb_sel_q <= 1'b0;
            rb_x_q <= 4'h0;
            input_q <= {NX*NY{1'b0}};
            switch_state <= {NX*NY{1'b0}};
            sda_out <= 1'b1;
            sda_oe <= 1'b0;
        end else begin
            scl_q <= scl_s;
            sda_q <= sda_s;
            if (start_c) begin
                // Repeated start restarts the address phase
                state_q <= S_RX;
                bit_q <= 4'h0;
                byte_q <= 2'h0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                state_q <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_RX: begin
                        if (scl_rise) begin
                            shift_q <= {shift_q[6:0], sda_s};
                            bit_q <= bit_q + 4'h1;
                        end else if (scl_fall && bit_q == 4'h8) begin
                            bit_q <= 4'h0;
                            if (byte_q == 2'h0) begin
                                if (shift_q[7:1] == dev_addr) begin
                                    rw_q <= shift_q[0];
                                    state_q <= S_ACK;
                                    sda_out <= 1'b0;
                                    sda_oe <= 1'b1;
                                end else begin
                                    state_q <= S_IDLE;
                                end
                            end else if (byte_q == 2'h1) begin
                                cmd_q <= shift_q;
                                rb_sel_q <= sel_hit;
                                rb_x_q <= sel_x;
                                state_q <= S_ACK;
                                sda_out <= 1'b0;
                                sda_oe <= 1'b1;
                            end else begin
                                state_q <= S_ACK;
                                sda_out <= 1'b0;
                                sda_oe <= 1'b1;
                                if (rb_sel_q) begin
                                    hold_q <= switch_state[rb_x_q*NY +: NY];
                                end else begin
                                    input_q <= input_d;
                                    if (shift_q[`LOAD_POS])
                                        switch_state <= input_d;
                                end
                            end
                            if (byte_q != 2'h3)
                                byte_q <= byte_q + 2'h1;
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (rw_q) begin
                                state_q <= S_TX;
                                shift_q <= (byte_q == 2'h1) ? 8'h00 : hold_q;
                                sda_out <= 1'b0;
                                sda_oe <= 1'b1;
                                byte_q <= byte_q + 2'h1;
                            end else begin
                                state_q <= S_RX;
                                sda_oe <= 1'b0;
                            end
                            bit_q <= 4'h0;
                        end
                    end
                    S_TX: begin
                        // Drive low bits only; high bits released
                        sda_oe <= ~shift_q[7];
                        sda_out <= 1'b0;
                        if (scl_fall) begin
                            bit_q <= bit_q + 4'h1;
                            if (bit_q == 4'h7) begin
                                state_q <= S_MACK;
                                sda_oe <= 1'b0;
                            end else begin
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe <= ~shift_q[6];
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            rw_q <= ~sda_s;
                        end else if (scl_fall) begin
                            bit_q <= 4'h0;
                            if (rw_q) begin
                                state_q <= S_TX;
                                shift_q <= (byte_q == 2'h2) ? hold_q : 8'h00;
                                sda_oe <= (byte_q == 2'h2) ? ~hold_q[7] : 1'b1;
                                if (byte_q != 2'h3)
                                    byte_q <= byte_q + 2'h1;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/i2c_master_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus master: drives the clock, pulls data low or releases it
module i2c_master_model (
    input wire logic mclk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_d
);
    // Both lines released while idle
    initial {scl, sda_d} = 2'b11;
    // Half bit time
    task automatic hp;
        repeat (10) @(negedge mclk);
    endtask
    // Start: data falls while clock high
    task automatic go;
        hp;
        sda_d = 0;
        hp;
        scl = 0;
    endtask
    // Stop: data rises while clock high
    task automatic halt;
        repeat (2) @(negedge mclk);
        sda_d = 0;
        hp;
        scl = 1;
        hp;
        sda_d = 1;
        hp;
    endtask
    // Nine bits MSB first; data moves just after clock low
    task automatic nine(input [8:0] d, output [8:0] q);
        for (int i = 8; i >= 0; i--) begin
            repeat (2) @(negedge mclk);
            sda_d = d[i];
            hp;
            scl = 1;
            repeat (5) @(negedge mclk);
            q[i] = sda_w;
            repeat (5) @(negedge mclk);
            scl = 0;
        end
    endtask
    task automatic wr(input [6:0] a, input [7:0] b1, input [7:0] b2,
                      output [2:0] nk);
        logic [8:0] q0, q1, q2;
        go;
        nine({a, 2'b01}, q0);
        nine({b1, 1'b1}, q1);
        nine({b2, 1'b1}, q2);
        halt;
        nk = {q0[0], q1[0], q2[0]};
    endtask
    // read two bytes, ack then nack
    task automatic rd(input [6:0] a, output [16:0] r);
        logic [8:0] q0, q1, q2;
        go;
        nine({a, 2'b11}, q0);
        nine(9'h1fe, q1);
        nine(9'h1ff, q2);
        halt;
        r = {q0[0], q1[8:1], q2[8:1]};
    endtask
endmodule
`default_nettype wire

// ==== testbench/i2c_crosspoint_switch_control_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches bus pins and switch outputs
module i2c_crosspoint_switch_control_checker #(
    parameter NX = 10,
    parameter NY = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [NX*NY-1:0] switch_state
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Bus framing events
    sequence s_start;
        scl_in && $fell(sda_in);
    endsequence
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    a_pull_low_only: assert property (sda_oe |-> !sda_out)
        else $error("data driven high");
    a_quiet_address: assert property (s_start |=> !sda_oe [*8])
        else $error("drive during address");
    a_idle_after_stop: assert property (s_stop |-> !sda_oe [*8])
        else $error("drive after stop");
    a_oe_held_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data moved with clock high");
    a_oe_rise_low: assert property (
        $rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("drive began off clock low");
    a_oe_bounded: assert property ($rose(sda_oe) |-> ##[1:500] !sda_oe)
        else $error("data held too long");
    a_switch_scl_low: assert property (
        $changed(switch_state) |-> !scl_in)
        else $error("switch moved with clock high");
    a_switch_with_ack: assert property (
        $changed(switch_state) |-> ##[0:6] sda_oe)
        else $error("switch moved without ack");
endmodule
bind i2c_crosspoint_switch_control i2c_crosspoint_switch_control_checker
    #(.NX(NX), .NY(NY)) u_chk (.mclk(mclk), .sys_rst(sys_rst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .switch_state(switch_state));
`default_nettype wire

// ==== testbench/i2c_crosspoint_switch_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "xpt_defines.vh"
// Self-checking bench, bus master model on the far side
module i2c_crosspoint_switch_control_tb;
    logic mclk = 0;
    logic sys_rst = 1;
    logic [6:0] dev_addr = 7'h70;
    wire scl, sda_d;
    logic sda_out, sda_oe;
    logic [79:0] switch_state, exp_sw = 0, exp_buf = 0;
    int num_errors = 0, checks_done = 0;
    logic [2:0] nk;
    logic [16:0] rb;
    // Open-drain data line with pull-up
    wire sda_w = sda_d & ~sda_oe;
    always #12.5 mclk = ~mclk;
    i2c_crosspoint_switch_control u_i2c_crosspoint_switch_control (
        .mclk(mclk), .sys_rst(sys_rst), .dev_addr(dev_addr),
        .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .switch_state(switch_state));
    i2c_master_model u_i2c_master_model (.mclk(mclk), .sda_w(sda_w),
        .scl(scl), .sda_d(sda_d));
    // Compare and count
    task automatic chk(input string what, input logic [79:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Command frame; expectation keeps buffer and active copy
    task automatic cmd(input [7:0] b1, input ld);
        int xi;
        // X codes 2..5 are lines 0..3, codes 8..13 lines 4..9
        xi = -1;
        if (b1[6:3] >= 2 && b1[6:3] <= 5)
            xi = b1[6:3] - 2;
        else if (b1[6:3] >= 8 && b1[6:3] <= 13)
            xi = b1[6:3] - 4;
        if (xi >= 0)
            exp_buf[xi*8 + b1[2:0]] = b1[7];
        if (ld)
            exp_sw = exp_buf;
        u_i2c_master_model.wr(dev_addr, b1, {7'h0, ld}, nk);
        chk("acks", nk, 0);
        chk("switches", switch_state, exp_sw);
    endtask
    task automatic t_reset;
        chk("rst switches", switch_state, 0);
        chk("rst drive", sda_oe, 0);
        chk("rst level", sda_out, 1);
        $display("reset test done");
    endtask
    // Buffered commands, reserved line, simultaneous load, off
    task automatic t_buffer;
        cmd(8'h9d, 1);
        cmd(8'h81, 0);
        cmd(8'hff, 0);
        cmd(8'h92, 0);
        cmd(8'hcf, 1);
        cmd(8'h1d, 1);
        cmd(8'hb0, 1);
        cmd(8'hea, 0);
        cmd(8'hc0, 1);
        $display("buffer test done");
    endtask
    // Reset in mid-run clears active and buffered states
    task automatic t_midreset;
        @(negedge mclk);
        sys_rst = 1;
        repeat (2) @(negedge mclk);
        sys_rst = 0;
        exp_sw = 0;
        exp_buf = 0;
        repeat (4) @(negedge mclk);
        chk("mid rst switches", switch_state, 0);
        cmd(8'h91, 1);
        $display("mid reset test done");
    endtask
    // Select each line, then read two bytes back
    task automatic t_readback;
        logic [7:0] rbc [10] = '{`RB_X0, `RB_X1, `RB_X2, `RB_X3,
            `RB_X4, `RB_X5, `RB_X6, `RB_X7, `RB_X8, `RB_X9};
        for (int x = 0; x < 10; x++) begin
            u_i2c_master_model.wr(dev_addr, rbc[x], 8'h00, nk);
            chk("sel acks", nk, 0);
            u_i2c_master_model.rd(dev_addr, rb);
            chk("rd ack", rb[16], 0);
            chk("zero byte", rb[15:8], 0);
            chk("y bits", rb[7:0], exp_sw[x*8 +: 8]);
        end
        chk("kept", switch_state, exp_sw);
        $display("readback test done");
    endtask
    // Another target's address: no ack, no change
    task automatic t_foreign;
        u_i2c_master_model.wr(dev_addr ^ 7'h01, 8'h90, 8'h01, nk);
        chk("no acks", nk, 3'b111);
        chk("untouched", switch_state, exp_sw);
        $display("foreign test done");
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 0;
        repeat (4) @(negedge mclk);
        t_reset;
        t_buffer;
        t_readback;
        t_midreset;
        t_foreign;
        tally_and_finish;
    end
endmodule
`default_nettype wire
